/* hdl/shared_port.sv */
// eight-bit bidirectional port with pin 7 function selection, wishbone slave
// Operation
// - direction bit 1 makes the pin an output, 0 makes it an input
// - direction register is write-only and every read returns all ones
// - reset or hard standby loads direction 00, or 80 in modes 3 and 4
// - modes 3 and 4 force pin 7 direction to one and drive address
// - soft standby keeps direction and data registers unchanged
// - pins with direction one keep driving during soft standby
// - port read gives data bit for outputs and pin level for inputs
// - data register is an eight-bit read/write store, one bit per pin
// - data register clears to 00 on reset or hard standby in any mode
// - normal modes pick pin 7 from timer setup, enable bit and direction
// - io control 0 with low bits nonzero gives compare output, else by direction
// - in normal modes pin 7 feeds capture input when io bit2 is 1 and pulse mode 0
`timescale 1ns/1ps
`include "port_a_params.svh"
module shared_port #(
    parameter int width = 8                              // pin count, fixed at eight
) (
    input  wire logic                    clk_i,          // system clock 100 MHz
    input  wire logic                    rst_i,          // synchronous reset, active high
    input  wire logic                    ce_i,           // clock enable, freezes state when low
    input  wire logic                    hw_standby_i,   // hardware standby, acts like reset
    input  wire logic                    sw_standby_i,   // software standby, registers hold
    input  wire port_a_pkg::mode_type    mode_i,         // operating mode 1..7
    input  wire logic [15:0]             adr_i,          // wishbone byte address low half
    input  wire logic [31:0]             dat_i,          // wishbone write data
    output logic [31:0]                  dat_o,          // wishbone read data
    input  wire logic                    we_i,           // wishbone write enable
    input  wire logic [3:0]              sel_i,          // wishbone byte selects
    input  wire logic                    cyc_i,          // wishbone cycle
    input  wire logic                    stb_i,          // wishbone strobe
    output logic                         ack_o,          // wishbone acknowledge
    input  wire logic                    compare_out_i,  // timer ch2 b-side compare output
    input  wire logic                    pattern_out_i,  // pattern unit output for pin 7
    input  wire logic                    addr_bit_i,     // high address bit 20
    input  wire port_a_pkg::byte_type    pin_i,          // pad input levels
    output port_a_pkg::byte_type         pin_o,          // pad output levels
    output port_a_pkg::byte_type         pin_oe_o,       // pad output enables, high drives
    output logic                         capture_o,      // pin 7 level to ch2 b-side capture
    output logic                         capture_en_o    // capture input routing active
);
    import port_a_pkg::*;

    // only eight pins are wired; any other width stops elaboration
    if (width != 8) begin : g_width_check
        $error("shared_port supports exactly eight pins");
    end

    byte_type      direction;
    byte_type      out_data;
    logic [7:0]    ctrl;
    byte_type      sync1;
    byte_type      sync2;
    byte_type      sync3;
    byte_type      pin_level;
    bus_state_type bus_state;
    pin7_func_type pin7_func;
    byte_type      next_pin_o;
    byte_type      next_pin_oe;
    byte_type      read_port;
    logic          addr_mode;
    logic          soft_rst;
    logic          wr_req;
    logic          pin7_dir;
    logic [2:0]    iob;

    // address modes are 3 and 4
    function automatic logic is_addr_mode(input mode_type m);
        return (m == 3'h3) || (m == 3'h4);
    endfunction

    // register address match for writes and reads, low byte lane carries the register
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    assign addr_mode = is_addr_mode(mode_i);
    assign soft_rst  = rst_i || hw_standby_i;
    assign wr_req    = cyc_i && stb_i && we_i && sel_i[0] && (bus_state == bus_idle)
                       && !sw_standby_i;
    assign iob       = ctrl[`CTRL_IOB_MSB:`CTRL_IOB_LSB];
    assign pin7_dir  = direction[7] || addr_mode;

    // pin synchroniser; change accepted once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1     <= 8'h00;
            sync2     <= 8'h00;
            sync3     <= 8'h00;
            pin_level <= 8'h00;
        end else if (ce_i) begin
            sync1 <= pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 8; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_level[i] <= sync3[i];
                end
            end
        end
    end

    // direction register; writes are blocked in soft standby so it holds
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            direction <= addr_mode ? `DIR_RESET_ADDR : `DIR_RESET_NORMAL;
        end else if (ce_i && wr_req && hit(adr_i, `DIR_OFFSET)) begin
            direction    <= dat_i[7:0];
            if (addr_mode) begin
                direction[7] <= 1'b1;
            end
        end
    end

    // data register, same hold behaviour in soft standby
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            out_data <= `DATA_RESET;
        end else if (ce_i && wr_req && hit(adr_i, `DATA_OFFSET)) begin
            out_data <= dat_i[7:0];
        end
    end

    // pin 7 selection inputs: next-data enable, pulse mode, b-side io control
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            ctrl <= `CTRL_RESET;
        end else if (ce_i && wr_req && hit(adr_i, `CTRL_OFFSET)) begin
            ctrl <= {3'h0, dat_i[4:0]};
        end
    end

    // pin 7 function decode for modes 1, 2, 5, 6, 7
    always_comb begin
        if (!iob[2] && (iob[1:0] != 2'b00)) begin
            pin7_func = pin7_compare;
        end else if (!pin7_dir) begin
            pin7_func = pin7_input;
        end else if (ctrl[`CTRL_NDE7_POS]) begin
            pin7_func = pin7_pattern;
        end else begin
            pin7_func = pin7_port;
        end
    end

    // pad drive; outputs keep driving in soft standby because registers hold
    always_comb begin
        next_pin_o  = out_data;
        next_pin_oe = direction;
        if (addr_mode) begin
            next_pin_o[7]  = addr_bit_i;
            next_pin_oe[7] = 1'b1;
        end else begin
            case (pin7_func)
                pin7_compare: begin
                    next_pin_o[7]  = compare_out_i;
                    next_pin_oe[7] = 1'b1;
                end
                pin7_pattern: begin
                    next_pin_o[7]  = pattern_out_i;
                    next_pin_oe[7] = 1'b1;
                end
                pin7_port: begin
                    next_pin_o[7]  = out_data[7];
                    next_pin_oe[7] = 1'b1;
                end
                default: begin
                    next_pin_o[7]  = out_data[7];
                    next_pin_oe[7] = 1'b0;
                end
            endcase
        end
    end

    // port read merges stored data and live pins per direction bit
    always_comb begin
        read_port = (out_data & direction) | (pin_level & ~direction);
        if (addr_mode) begin
            read_port[7] = out_data[7];
        end
    end

    // registered pad outputs and capture routing
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            pin_o        <= 8'h00;
            pin_oe_o     <= 8'h00;
            capture_o    <= 1'b0;
            capture_en_o <= 1'b0;
        end else if (ce_i) begin
            pin_o        <= next_pin_o;
            pin_oe_o     <= next_pin_oe;
            capture_en_o <= !addr_mode && iob[2] && !ctrl[`CTRL_CH2_PULSE_WIDTH_MODE_POS];
            capture_o    <= (!addr_mode && iob[2] && !ctrl[`CTRL_CH2_PULSE_WIDTH_MODE_POS])
                            ? pin_level[7] : 1'b0;
        end
    end

    // wishbone slave: one-cycle ack, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state <= bus_idle;
            ack_o     <= 1'b0;
            dat_o     <= 32'h0;
        end else if (ce_i) begin
            case (bus_state)
                bus_idle: begin
                    if (cyc_i && stb_i) begin
                        bus_state <= bus_ack;
                        ack_o     <= 1'b1;
                        if (hit(adr_i, `DIR_OFFSET)) begin
                            dat_o <= {24'h0, `DIR_READ_VALUE};
                        end else if (hit(adr_i, `DATA_OFFSET)) begin
                            dat_o <= {24'h0, read_port};
                        end else if (hit(adr_i, `CTRL_OFFSET)) begin
                            dat_o <= {24'h0, ctrl};
                        end else begin
                            dat_o <= 32'h0;
                        end
                    end
                end
                default: begin
                    bus_state <= bus_idle;
                    ack_o     <= 1'b0;
                end
            endcase
        end
    end

    // checks
    property p_dir_read;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && cyc_i && stb_i && !we_i && bus_state == bus_idle && adr_i == `DIR_OFFSET)
        |=> (ack_o && dat_o[7:0] == 8'hff);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read not all ones");

    property p_reset_dir;
        @(posedge clk_i) (rst_i && addr_mode) |=> (direction == 8'h80);
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("direction reset wrong");

    property p_reset_data;
        @(posedge clk_i) rst_i |=> (out_data == 8'h00);
    endproperty
    a_reset_data: assert property (p_reset_data) else $error("data not cleared");

    property p_pin7_forced;
        @(posedge clk_i) disable iff (rst_i || hw_standby_i)
        (ce_i && addr_mode) |=> (pin_oe_o[7] && pin_o[7] == $past(addr_bit_i));
    endproperty
    a_pin7_forced: assert property (p_pin7_forced) else $error("pin7 not address");

    property p_hold_sw;
        @(posedge clk_i) disable iff (rst_i || hw_standby_i)
        sw_standby_i |=> ($stable(direction) && $stable(out_data));
    endproperty
    a_hold_sw: assert property (p_hold_sw) else $error("registers changed in standby");

    property p_oe_follows;
        @(posedge clk_i) disable iff (soft_rst)
        ce_i |=> (pin_oe_o[6:0] == $past(direction[6:0]));
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("output enable mismatch");

    property p_data_write;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && wr_req && adr_i == `DATA_OFFSET) |=> (out_data == $past(dat_i[7:0]));
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_compare;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && !addr_mode && !iob[2] && iob[1:0] != 2'b00)
        |=> (pin_oe_o[7] && pin_o[7] == $past(compare_out_i));
    endproperty
    a_compare: assert property (p_compare) else $error("compare output not routed");

    property p_capture;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && !addr_mode && iob[2] && !ctrl[`CTRL_CH2_PULSE_WIDTH_MODE_POS]) |=> capture_en_o;
    endproperty
    a_capture: assert property (p_capture) else $error("capture not routed");

    property p_drive_sw;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && sw_standby_i && direction[0]) |=> pin_oe_o[0];
    endproperty
    a_drive_sw: assert property (p_drive_sw) else $error("output dropped in standby");

    property p_pattern;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && pin7_func == pin7_pattern && !addr_mode) |=> pin_o[7] == $past(pattern_out_i);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern not routed");

    // reset clears direction outside the address modes as well
    property p_dir_clear;
        @(posedge clk_i) (soft_rst && !addr_mode) |=> (direction == `DIR_RESET_NORMAL);
    endproperty
    a_dir_clear: assert property (p_dir_clear) else $error("direction not cleared");

    property p_hw_data;
        @(posedge clk_i) hw_standby_i |=> (out_data == `DATA_RESET);
    endproperty
    a_hw_data: assert property (p_hw_data) else $error("data kept in hard standby");

    property p_pin7_input;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && !addr_mode && (iob[2] || iob[1:0] == 2'b00) && !direction[7]) |=> !pin_oe_o[7];
    endproperty
    a_pin7_input: assert property (p_pin7_input) else $error("pin7 driven as input");

    property p_capture_level;
        @(posedge clk_i) disable iff (soft_rst)
        (ce_i && !addr_mode && iob[2] && !ctrl[`CTRL_CH2_PULSE_WIDTH_MODE_POS])
        |=> (capture_o == $past(pin_level[7]));
    endproperty
    a_capture_level: assert property (p_capture_level) else $error("capture level wrong");

    // the acknowledge is a single-cycle pulse; a held strobe is answered again every second cycle
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) (ack_o && ce_i) |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");

    property p_data_read;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && cyc_i && stb_i && !we_i && bus_state == bus_idle && adr_i == `DATA_OFFSET)
        |=> (dat_o[7:0] == (($past(out_data) & $past(direction))
                            | ($past(pin_level) & ~$past(direction))));
    endproperty
    a_data_read: assert property (p_data_read) else $error("port read merge wrong");

    // a low clock enable must hold the three port registers, pads, capture level and acknowledge
    property p_freeze;
        @(posedge clk_i) disable iff (soft_rst)
        !ce_i |=> ($stable(direction) && $stable(out_data) && $stable(ctrl)
                   && $stable(pin_o) && $stable(pin_oe_o)
                   && $stable(capture_o) && $stable(ack_o));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    c_write: cover property (@(posedge clk_i) wr_req ##1 ack_o);
    c_standby: cover property (@(posedge clk_i) sw_standby_i && direction != 8'h00);
    c_pattern: cover property (@(posedge clk_i) pin7_func == pin7_pattern);
    c_capture: cover property (@(posedge clk_i) capture_en_o && capture_o);
    c_addr_mode: cover property (@(posedge clk_i) addr_mode && pin_oe_o[7] && pin_o[7]);
endmodule

/* hdl/port_a_params.svh */
// constants for the eight-bit shared-pin port: offsets, reset values, timing
`ifndef PORT_A_PARAMS_SVH
`define PORT_A_PARAMS_SVH
`define DIR_OFFSET        16'hffd1
`define DATA_OFFSET       16'hffd3
`define CTRL_OFFSET       16'hffd5
`define DIR_RESET_NORMAL  8'h00
`define DIR_RESET_ADDR    8'h80
`define DATA_RESET        8'h00
`define CTRL_RESET        8'h00
`define DIR_READ_VALUE    8'hff
`define PIN7_POS          3
`define CTRL_NDE7_POS     0
`define CTRL_CH2_PULSE_WIDTH_MODE_POS     1
`define CTRL_IOB_LSB      2
`define CTRL_IOB_MSB      4
`define SYNC_STAGES       3
`endif

/* hdl/port_a_pkg.sv */
// types shared by the eight-bit shared-pin port
package port_a_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [2:0] mode_type;
    typedef enum logic [1:0] {
        pin7_input   = 2'b00,
        pin7_port    = 2'b01,
        pin7_pattern = 2'b10,
        pin7_compare = 2'b11
    } pin7_func_type;
    typedef enum logic [0:0] {
        bus_idle = 1'b0,
        bus_ack  = 1'b1
    } bus_state_type;
endpackage

/* testbench/pad_partner.sv */
// pad-side model: pull-ups plus an outside driver on pins the port releases
`timescale 1ns/1ps
module pad_partner (
    input  wire logic [7:0] drv_i,     // levels the port drives
    input  wire logic [7:0] drv_en_i,  // port drive enables, high drives
    input  wire logic [7:0] ext_val_i, // level the outside circuit drives
    input  wire logic [7:0] ext_en_i,  // outside circuit drive enables
    output logic      [7:0] pad_o      // resolved pad levels
);
    // port driver wins; a pad nobody drives floats up through its pull-up
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            pad_o[b] = drv_en_i[b] ? drv_i[b] : (ext_en_i[b] ? ext_val_i[b] : 1'b1);
        end
    end
endmodule

/* testbench/shared_port_bench.sv */
// self-checking bench for the eight-bit shared-pin port
`timescale 1ns/1ps
`include "port_a_params.svh"
module shared_port_bench;
    import port_a_pkg::*;
    logic clk_i, rst_i, hw_i, sw_i, we_i, cyc_i, stb_i, ack_o, ce_i;
    logic cmp_i, pat_i, adb_i, cap_o, cap_en_o;
    mode_type mode_i;
    logic [15:0] adr_i;
    logic [31:0] dat_i, dat_o;
    logic [3:0] sel_i;
    byte_type pin_i, pin_o, pin_oe_o, ext_val, ext_en, q;
    int errors, samples_checked;

    shared_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hw_standby_i(hw_i),
        .sw_standby_i(sw_i), .mode_i(mode_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .compare_out_i(cmp_i), .pattern_out_i(pat_i), .addr_bit_i(adb_i), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .capture_o(cap_o), .capture_en_o(cap_en_o));
    pad_partner u_pads (.drv_i(pin_o), .drv_en_i(pin_oe_o), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pad_o(pin_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input byte_type seen, input byte_type exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; waits for ack under a bound, then idles one cycle
    task automatic wb(input logic w, input logic [15:0] a, input byte_type d);
        int n;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; sel_i <= 4'h1; adr_i <= a; dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        if (ack_o !== 1'b1) begin
            errors++;
            test_done();
        end
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic reset_in(input mode_type m);
        rst_i <= 1'b1; mode_i <= m;
        tick(4);
        rst_i <= 1'b0;
        tick(1);
    endtask

    task automatic t_reset();
        reset_in(3'd1);
        wb(1'b0, `DIR_OFFSET, 8'h00); chk("dir read", q, 8'hff);
        chk("oe after reset", pin_oe_o, 8'h00);
        ext_en <= 8'hff; ext_val <= 8'ha5;
        tick(6);
        wb(1'b0, `DATA_OFFSET, 8'h00); chk("input pins", q, 8'ha5);
        wb(1'b0, 16'hffd7, 8'h00); chk("unmapped read", q, 8'h00);
    endtask

    task automatic t_io();
        wb(1'b1, `DIR_OFFSET, 8'h0f); wb(1'b1, `DATA_OFFSET, 8'h3c);
        tick(2);
        chk("oe", pin_oe_o, 8'h0f);
        chk("low outputs", pin_o & 8'h0f, 8'h0c);
        ext_val <= 8'h50;
        tick(6);
        wb(1'b0, `DATA_OFFSET, 8'h00); chk("mixed read", q, 8'h5c);
        wb(1'b0, `DIR_OFFSET, 8'h00); chk("dir read", q, 8'hff);
    endtask

    task automatic t_standby();
        sw_i <= 1'b1;
        wb(1'b1, `DATA_OFFSET, 8'h00); wb(1'b1, `DIR_OFFSET, 8'h00);
        tick(2);
        chk("oe soft standby", pin_oe_o, 8'h0f);
        chk("out soft standby", pin_o & 8'h0f, 8'h0c);
        sw_i <= 1'b0;
        wb(1'b0, `DATA_OFFSET, 8'h00); chk("data kept", q, 8'h5c);
        hw_i <= 1'b1;
        tick(2);
        hw_i <= 1'b0;
        tick(2);
        chk("oe hard standby", pin_oe_o, 8'h00);
        wb(1'b1, `DIR_OFFSET, 8'hff);
        wb(1'b0, `DATA_OFFSET, 8'h00); chk("data cleared", q, 8'h00);
    endtask

    // pin 7 selection: control value, compare level, pattern level, pin level
    task automatic t_pin7();
        byte_type tbl[7][4] = '{'{8'h05, 8'h01, 8'h00, 8'h01}, '{8'h09, 8'h01, 8'h00, 8'h01},
            '{8'h0d, 8'h01, 8'h00, 8'h01}, '{8'h01, 8'h00, 8'h01, 8'h01},
            '{8'h00, 8'h01, 8'h01, 8'h00}, '{8'h11, 8'h00, 8'h01, 8'h01},
            '{8'h13, 8'h00, 8'h01, 8'h01}};
        reset_in(3'd1);
        wb(1'b1, `DIR_OFFSET, 8'h80); wb(1'b1, `DATA_OFFSET, 8'h00);
        foreach (tbl[i]) begin
            cmp_i <= tbl[i][1][0]; pat_i <= tbl[i][2][0];
            wb(1'b1, `CTRL_OFFSET, tbl[i][0]);
            tick(2);
            chk("pin7 level", {7'h0, pin_o[7]}, tbl[i][3]);
            chk("pin7 oe", {7'h0, pin_oe_o[7]}, 8'h01);
            chk("capture route", {7'h0, cap_en_o}, {7'h0, tbl[i][0][4] & ~tbl[i][0][1]});
        end
    endtask

    // pin 7 as plain input feeding capture; a low clock enable freezes the chain
    task automatic t_capture();
        wb(1'b1, `DIR_OFFSET, 8'h00); wb(1'b1, `CTRL_OFFSET, 8'h10);
        ext_val <= 8'h80;
        tick(6);
        chk("pin7 input oe", {7'h0, pin_oe_o[7]}, 8'h00);
        chk("capture level", {7'h0, cap_o}, 8'h01);
        wb(1'b0, `DATA_OFFSET, 8'h00); chk("pin7 read", q, 8'h80);
        ce_i <= 1'b0; ext_val <= 8'h00;
        tick(6);
        chk("capture frozen", {7'h0, cap_o}, 8'h01);
        ce_i <= 1'b1;
        tick(6);
        chk("capture follows", {7'h0, cap_o}, 8'h00);
    endtask

    task automatic t_mode3();
        adb_i <= 1'b1;
        reset_in(3'd3);
        tick(2);
        chk("oe mode 3", pin_oe_o, 8'h80);
        chk("pin7 address", {7'h0, pin_o[7]}, 8'h01);
        wb(1'b1, `DIR_OFFSET, 8'h00);
        tick(2);
        chk("pin7 forced", {7'h0, pin_oe_o[7]}, 8'h01);
        wb(1'b1, `DATA_OFFSET, 8'h80);
        wb(1'b0, `DATA_OFFSET, 8'h00); chk("pin7 stored read", q, 8'h80);
        adb_i <= 1'b0;
        tick(2);
        chk("pin7 address low", {7'h0, pin_o[7]}, 8'h00);
    endtask

    initial begin
        hw_i = 1'b0; sw_i = 1'b0; we_i = 1'b0; cyc_i = 1'b0; stb_i = 1'b0; ce_i = 1'b1;
        cmp_i = 1'b0; pat_i = 1'b0; adb_i = 1'b0; adr_i = 16'h0;
        dat_i = 32'h0; sel_i = 4'h1; ext_val = 8'h00; ext_en = 8'h00;
        errors = 0; samples_checked = 0;
        t_reset();
        t_io();
        t_standby();
        t_pin7();
        t_capture();
        t_mode3();
        test_done();
    end
endmodule
